// [rtl/pcp_protection.sv]
// Summary of operation
// - short circuit selects off, trip, aux, both
// - both selection energises trip and aux together
// - short circuit lights trip and aux indicators
// - short circuit armed in every state unless off
// - short circuit pickup one to eleven times CT
// - any phase at pickup for delay fires
// - short circuit delay zero or up to 60000ms; code stores any 16-bit value, 65535 never fires
// - zero delay output within 45 ms
// - overload alarm immediate above pickup while running
// - overload alarm during start after inhibit delay
// - jam fires when average above pickup for delay
// - jam trip records cause; alarm gives message
// - jam during start only after its inhibit
// - undercurrent alarm drives alarm and message
// - undercurrent trip energises trip, records cause
// - undercurrent aux energises aux, no message
// - undercurrent evaluated only at or above five percent load
// - undercurrent fires after pickup held for delay
`timescale 1ns/1ps
`default_nettype none
module pcp_protection #(
    parameter int MS_CYCLES = pcp_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // axi4-lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // measured phase currents, amps, same clock domain
    input  wire logic [15:0] phaseA,
    input  wire logic [15:0] phaseB,
    input  wire logic [15:0] phaseC,
    // motor state
    input  wire logic        motorRunning,
    input  wire logic        motorStarting,
    // relay drivers and indicators
    output var  logic        tripRelay,
    output var  logic        auxRelay,
    output var  logic        alarmRelay,
    output var  logic        tripLed,
    output var  logic        auxLed,
    // display messages
    output var  logic        iolAlarmMsg,
    output var  logic        jamAlarmMsg,
    output var  logic        ucAlarmMsg,
    output var  logic [1:0]  lastTripCause
);
    localparam int NT = 5;
    localparam int PW = $clog2(MS_CYCLES);

    initial begin
        if (MS_CYCLES < 2 || MS_CYCLES > 65536) begin
            $error("MS_CYCLES out of range");
        end
    end

    // configuration registers
    logic [1:0]  scSel;
    logic [2:0]  jamSel;
    logic [1:0]  ucSel;
    logic        iolEnable;
    logic [3:0]  scMult;
    logic [15:0] scDelay;
    logic [15:0] ctPrimary;
    logic [15:0] full_load_current;
    logic [6:0]  iolPickup;
    logic [15:0] iolInhibit;
    logic [6:0]  jamPickup;
    logic [15:0] jamDelay;
    logic [15:0] jamInhibit;
    logic [6:0]  ucPickup;
    logic [15:0] ucDelay;

    // millisecond time base
    logic [PW-1:0] preCnt;
    logic          msTick;

    // timer array: 0 sc, 1 jam, 2 uc, 3 overload inhibit, 4 jam inhibit
    logic [15:0]   tmrCnt [NT];
    logic [15:0]   tmrDly [NT];
    logic [NT-1:0] tmrIn;
    logic [NT-1:0] tmrDone;

    // current comparisons, averages kept as sums to avoid a divider
    wire [31:0] phSum   = 32'(phaseA) + 32'(phaseB) + 32'(phaseC);
    wire [31:0] scLevel = 32'(scMult) * 32'(ctPrimary);
    wire [31:0] flcN    = pcp_pkg::AVG_N * 32'(full_load_current);
    wire scCond  = (32'(phaseA) >= scLevel) || (32'(phaseB) >= scLevel)
                   || (32'(phaseC) >= scLevel);
    wire iolCond = phSum * pcp_pkg::TENTHS > flcN * 32'(iolPickup);
    wire jamCond = phSum * pcp_pkg::TENTHS > flcN * 32'(jamPickup);
    wire ucFloor = phSum * pcp_pkg::PERCENT >= flcN * pcp_pkg::UC_MIN_PCT;
    wire ucCond  = ucFloor && (phSum * pcp_pkg::PERCENT < flcN * 32'(ucPickup));

    // qualified function conditions
    wire scArmed  = scSel != pcp_pkg::SC_OFF;
    wire jamArmed = jamSel != pcp_pkg::JAM_OFF;
    wire ucArmed  = ucSel != pcp_pkg::UC_OFF;
    wire jamQual  = jamArmed && jamCond
                    && (motorRunning || (motorStarting && tmrDone[4]));
    wire iolAct   = iolEnable && iolCond
                    && (motorRunning || (motorStarting && tmrDone[3]));
    wire ucQual   = ucArmed && ucCond && motorRunning;

    // timer inputs and delays
    assign tmrIn[0] = scArmed && scCond;
    assign tmrIn[1] = jamQual;
    assign tmrIn[2] = ucQual;
    assign tmrIn[3] = iolEnable && iolCond && motorStarting;
    assign tmrIn[4] = jamArmed && jamCond && motorStarting;
    assign tmrDly[0] = scDelay;
    assign tmrDly[1] = jamDelay;
    assign tmrDly[2] = ucDelay;
    assign tmrDly[3] = iolInhibit;
    assign tmrDly[4] = jamInhibit;

    // prescaler for the millisecond tick, free running
    always_ff @(posedge clk) begin
        if (!nrst) begin
            preCnt <= '0;
        end else if (preCnt == PW'(MS_CYCLES - 1)) begin
            preCnt <= '0;
        end else begin
            preCnt <= preCnt + PW'(1);
        end
    end
    assign msTick = preCnt == PW'(MS_CYCLES - 1);

    // delay timers; the free tick means up to one ms less delay than set
    genvar g;
    for (g = 0; g < NT; g++) begin : gTmr
        always_ff @(posedge clk) begin
            if (!nrst || !tmrIn[g]) begin
                tmrCnt[g] <= '0;
            end else if (msTick && tmrCnt[g] != pcp_pkg::DLY_UNLIMITED) begin
                tmrCnt[g] <= tmrCnt[g] + 16'h1;
            end
        end
        // unlimited never completes: the count saturates at it, so it is excluded here
        assign tmrDone[g] = tmrIn[g] && (tmrCnt[g] >= tmrDly[g])
                            && (tmrDly[g] != pcp_pkg::DLY_UNLIMITED);
    end

    // relay requests per function
    wire scFire   = tmrDone[0];
    wire jamFire  = tmrDone[1];
    wire ucFire   = tmrDone[2];
    wire scTrip   = scFire && (scSel == pcp_pkg::SC_TRIP
                    || scSel == pcp_pkg::SC_BOTH);
    wire scAux    = scFire && (scSel == pcp_pkg::SC_AUX
                    || scSel == pcp_pkg::SC_BOTH);
    wire jamTrip  = jamFire && (jamSel == pcp_pkg::JAM_TRIP
                    || jamSel == pcp_pkg::JAM_BOTH);
    wire jamAux   = jamFire && (jamSel == pcp_pkg::JAM_AUX
                    || jamSel == pcp_pkg::JAM_BOTH);
    wire jamIsTrip = jamTrip || jamAux;
    wire jamAlarm = jamFire && jamSel == pcp_pkg::JAM_ALARM;
    wire ucAlarm  = ucFire && ucSel == pcp_pkg::UC_ALARM;
    wire ucTrip   = ucFire && ucSel == pcp_pkg::UC_TRIP;
    wire ucAux    = ucFire && ucSel == pcp_pkg::UC_AUX;

    // cause of the newest trip, short circuit first if simultaneous
    wire [1:0] next_cause = scFire    ? pcp_pkg::CAUSE_SC :
                            jamIsTrip ? pcp_pkg::CAUSE_JAM :
                            ucTrip    ? pcp_pkg::CAUSE_UC : lastTripCause;

    // outputs follow the conditions; latching is done elsewhere
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tripRelay     <= 1'b0;
            auxRelay      <= 1'b0;
            alarmRelay    <= 1'b0;
            tripLed       <= 1'b0;
            auxLed        <= 1'b0;
            iolAlarmMsg   <= 1'b0;
            jamAlarmMsg   <= 1'b0;
            ucAlarmMsg    <= 1'b0;
            lastTripCause <= pcp_pkg::CAUSE_NONE;
        end else begin
            tripRelay     <= scTrip || jamTrip || ucTrip;
            auxRelay      <= scAux || jamAux || ucAux;
            alarmRelay    <= iolAct || jamAlarm || ucAlarm;
            tripLed       <= scFire || jamTrip || ucTrip;
            auxLed        <= scFire || jamAux || ucAux;
            iolAlarmMsg   <= iolAct;
            jamAlarmMsg   <= jamAlarm;
            ucAlarmMsg    <= ucAlarm;
            lastTripCause <= next_cause;
        end
    end

    // clamp a pickup field into its permitted range
    function automatic logic [6:0] clampField(input logic [6:0] v,
                                              input logic [6:0] lo,
                                              input logic [6:0] hi);
        return (v < lo) ? lo : (v > hi) ? hi : v;
    endfunction

    // register images as software sees them
    wire [31:0] imgCtrl   = {24'h0, ucSel, jamSel, iolEnable, scSel};
    wire [31:0] imgSc     = {scDelay, 12'h0, scMult};
    wire [31:0] imgRating = {full_load_current, ctPrimary};
    wire [31:0] imgIol    = {iolInhibit, 9'h0, iolPickup};
    wire [31:0] imgJam    = {jamDelay, 9'h0, jamPickup};
    wire [31:0] imgJamInh = {16'h0, jamInhibit};
    wire [31:0] imgUc     = {ucDelay, 9'h0, ucPickup};
    wire [31:0] imgStatus = {20'h0, motorStarting, motorRunning, lastTripCause,
                             ucAlarmMsg, jamAlarmMsg, iolAlarmMsg, auxLed,
                             tripLed, alarmRelay, auxRelay, tripRelay};

    // write decode
    wire        wrGo  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire        wrAct = s_axi_awready;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    wire [7:0]  wAd   = {wrAddr[7:2], 2'h0};
    wire        wrHit = wAd <= pcp_pkg::OFF_UC;
    wire [31:0] wrOld = wAd == pcp_pkg::OFF_CTRL   ? imgCtrl :
                        wAd == pcp_pkg::OFF_SC     ? imgSc :
                        wAd == pcp_pkg::OFF_RATING ? imgRating :
                        wAd == pcp_pkg::OFF_IOL    ? imgIol :
                        wAd == pcp_pkg::OFF_JAM    ? imgJam :
                        wAd == pcp_pkg::OFF_JAMINH ? imgJamInh : imgUc;
    wire [31:0] wrNew;
    for (g = 0; g < 4; g++) begin : gLane
        assign wrNew[8*g +: 8] = wrStrb[g] ? wrData[8*g +: 8] : wrOld[8*g +: 8];
    end
    wire [6:0]  scM   = clampField({3'h0, wrNew[3:0]}, {3'h0, pcp_pkg::SC_MULT_MIN},
                                   {3'h0, pcp_pkg::SC_MULT_MAX});

    // write channel handshake; both channels taken in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= pcp_pkg::RESP_OKAY;
            wrAddr        <= '0;
            wrData        <= '0;
            wrStrb        <= '0;
        end else begin
            s_axi_awready <= wrGo;
            s_axi_wready  <= wrGo;
            if (wrGo) begin
                wrAddr <= s_axi_awaddr;
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
            end
            if (wrAct) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? pcp_pkg::RESP_OKAY : pcp_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration storage; defaults leave every function off
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scSel <= pcp_pkg::SC_OFF;
            jamSel <= pcp_pkg::JAM_OFF;
            ucSel <= pcp_pkg::UC_OFF;
            iolEnable <= 1'b0;
            scMult <= pcp_pkg::SC_MULT_MAX;
            scDelay <= '0;
            ctPrimary <= '0;
            full_load_current <= '0;
            iolPickup <= pcp_pkg::IOL_TENTH_MAX;
            iolInhibit <= pcp_pkg::DLY_UNLIMITED;
            jamPickup <= pcp_pkg::IOL_TENTH_MAX;
            jamDelay <= '0;
            jamInhibit <= pcp_pkg::DLY_UNLIMITED;
            ucPickup <= '0;
            ucDelay <= '0;
        end else if (wrAct && wrHit) begin
            case (wAd)
                pcp_pkg::OFF_CTRL: begin
                    scSel     <= wrNew[1:0];
                    iolEnable <= wrNew[2];
                    jamSel    <= (wrNew[5:3] > pcp_pkg::JAM_ALARM) ? pcp_pkg::JAM_OFF
                                 : wrNew[5:3];
                    ucSel     <= wrNew[7:6];
                end
                pcp_pkg::OFF_SC: begin
                    scMult  <= scM[3:0];
                    scDelay <= wrNew[31:16];
                end
                pcp_pkg::OFF_RATING: begin
                    ctPrimary         <= wrNew[15:0];
                    full_load_current <= wrNew[31:16];
                end
                pcp_pkg::OFF_IOL: begin
                    iolPickup  <= clampField(wrNew[6:0], pcp_pkg::IOL_TENTH_MIN,
                                             pcp_pkg::IOL_TENTH_MAX);
                    iolInhibit <= wrNew[31:16];
                end
                pcp_pkg::OFF_JAM: begin
                    jamPickup <= wrNew[6:0];
                    jamDelay  <= wrNew[31:16];
                end
                pcp_pkg::OFF_JAMINH: begin
                    jamInhibit <= wrNew[15:0];
                end
                default: begin
                    ucPickup <= wrNew[6:0];
                    ucDelay  <= wrNew[31:16];
                end
            endcase
        end
    end

    // read decode
    wire [7:0]  rAd   = {s_axi_araddr[7:2], 2'h0};
    wire        rdHit = rAd <= pcp_pkg::OFF_STATUS;
    wire [31:0] rdMux = rAd == pcp_pkg::OFF_CTRL   ? imgCtrl :
                        rAd == pcp_pkg::OFF_SC     ? imgSc :
                        rAd == pcp_pkg::OFF_RATING ? imgRating :
                        rAd == pcp_pkg::OFF_IOL    ? imgIol :
                        rAd == pcp_pkg::OFF_JAM    ? imgJam :
                        rAd == pcp_pkg::OFF_JAMINH ? imgJamInh :
                        rAd == pcp_pkg::OFF_UC     ? imgUc :
                        rAd == pcp_pkg::OFF_STATUS ? imgStatus : 32'h0;
    wire        rdGo  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

    // read channel; data captured when the address is taken
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= pcp_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= rdGo;
            if (rdGo) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdMux;
                s_axi_rresp  <= rdHit ? pcp_pkg::RESP_OKAY : pcp_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/pcp_pkg.sv]
package pcp_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int ZERO_INTENTIONAL_DELAY_BOUND_MS = 45;    // worst case with zero intentional delay
    localparam int SC_DELAY_MAX_MS = 60000;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_SC     = 8'h04;
    localparam logic [7:0] OFF_RATING = 8'h08;
    localparam logic [7:0] OFF_IOL    = 8'h0c;
    localparam logic [7:0] OFF_JAM    = 8'h10;
    localparam logic [7:0] OFF_JAMINH = 8'h14;
    localparam logic [7:0] OFF_UC     = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;

    // selections
    localparam logic [1:0] SC_OFF = 2'h0;
    localparam logic [1:0] SC_TRIP = 2'h1;
    localparam logic [1:0] SC_AUX = 2'h2;
    localparam logic [1:0] SC_BOTH = 2'h3;
    localparam logic [2:0] JAM_OFF = 3'h0;
    localparam logic [2:0] JAM_TRIP = 3'h1;
    localparam logic [2:0] JAM_AUX = 3'h2;
    localparam logic [2:0] JAM_BOTH = 3'h3;
    localparam logic [2:0] JAM_ALARM = 3'h4;
    localparam logic [1:0] UC_OFF = 2'h0;
    localparam logic [1:0] UC_ALARM = 2'h1;
    localparam logic [1:0] UC_TRIP = 2'h2;
    localparam logic [1:0] UC_AUX = 2'h3;

    // cause of last trip codes
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_SC   = 2'h1;
    localparam logic [1:0] CAUSE_JAM  = 2'h2;
    localparam logic [1:0] CAUSE_UC   = 2'h3;

    // pickup ranges and scaling
    localparam logic [3:0]  SC_MULT_MIN  = 4'h1;
    localparam logic [3:0]  SC_MULT_MAX  = 4'hb;
    localparam logic [6:0]  IOL_TENTH_MIN = 7'h05;
    localparam logic [6:0]  IOL_TENTH_MAX = 7'h6e;
    localparam logic [31:0] AVG_N      = 32'h3;
    localparam logic [31:0] TENTHS     = 32'ha;
    localparam logic [31:0] PERCENT    = 32'h64;
    localparam logic [31:0] UC_MIN_PCT = 32'h5;
    localparam logic [15:0] DLY_UNLIMITED = 16'hffff;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [test/pcp_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module pcp_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // register bus handshakes
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    // relays and messages
    input wire logic       tripRelay,
    input wire logic       auxRelay,
    input wire logic       alarmRelay,
    input wire logic       iolAlarmMsg,
    input wire logic       jamAlarmMsg,
    input wire logic       ucAlarmMsg,
    input wire logic [1:0] lastTripCause
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // write taken only with both halves, answered two cycles on
    property p_aw_take;
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
            |=> s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
    endproperty
    a_aw_take: assert property (p_aw_take) else $error("write not answered in time");
    property p_aw_pulse;
        $rose(s_axi_awready) |-> s_axi_wready ##1 !s_axi_awready;
    endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("address and data ready differ");
    // a response never appears without a taken write
    property p_b_cause;
        $rose(s_axi_bvalid) |-> $past(s_axi_awready);
    endproperty
    a_b_cause: assert property (p_b_cause) else $error("response without a write");
    property p_b_drop;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop) else $error("response not released");
    property p_ar_take;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
    endproperty
    a_ar_take: assert property (p_ar_take) else $error("read not answered in one cycle");
    property p_r_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_drop: assert property (p_r_drop) else $error("read data not released");
    // a new trip cause comes only together with a tripping output
    property p_cause;
        $changed(lastTripCause) |-> tripRelay || auxRelay;
    endproperty
    a_cause: assert property (p_cause) else $error("cause changed without a trip");
    property p_msg_alarm;
        iolAlarmMsg || jamAlarmMsg || ucAlarmMsg |-> alarmRelay;
    endproperty
    a_msg_alarm: assert property (p_msg_alarm) else $error("message without alarm");

    // main scenarios reached
    c_both: cover property (tripRelay && auxRelay);
    c_jam: cover property (jamAlarmMsg);
    c_refused: cover property (s_axi_bvalid && s_axi_bresp == pcp_pkg::RESP_SLVERR);
endmodule

bind pcp_protection pcp_checker u_chk (.*);
`default_nettype wire

// [test/pcp_ct_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pcp_ct_model (
    // sampling clock
    input  wire logic        clk,
    // primary currents to reproduce
    input  wire logic [15:0] ampA,
    input  wire logic [15:0] ampB,
    input  wire logic [15:0] ampC,
    // converted readings
    output var  logic [15:0] phaseA,
    output var  logic [15:0] phaseB,
    output var  logic [15:0] phaseC
);
    // one sample of lag, as a real converter has
    always_ff @(posedge clk) begin
        phaseA <= ampA;
        phaseB <= ampB;
        phaseC <= ampC;
    end
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int MS = 20;
    logic        clk = 1'b0, nrst = 1'b0, motorRunning = 1'b0, motorStarting = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, lastTripCause;
    logic [15:0] ampA = 16'h0, ampB = 16'h0, ampC = 16'h0, phaseA, phaseB, phaseC;
    logic        tripRelay, auxRelay, alarmRelay, tripLed, auxLed;
    logic        iolAlarmMsg, jamAlarmMsg, ucAlarmMsg;
    wire  [7:0]  outs = {ucAlarmMsg, jamAlarmMsg, iolAlarmMsg, auxLed, tripLed,
                         alarmRelay, auxRelay, tripRelay};
    int          error_cnt = 0, num_checks = 0, seed = 81, cycles = 0, i;

    pcp_protection #(.MS_CYCLES(MS)) uut (.*);
    pcp_ct_model ct (.*);

    always #25 clk = ~clk;
    // hang guard, well above the length of the sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic amps(input int a, input int b, input int c);
        ampA <= 16'(a);
        ampB <= 16'(b);
        ampC <= 16'(c);
    endtask
    // address and data offered together, response awaited after
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        @(posedge clk); // keeps bready low for one edge before the next write
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata}, {er, ed});
        @(posedge clk); // keeps arvalid low for one edge before the next read
    endtask
    function automatic logic [7:0] exp_sc(input logic [1:0] s);
        return {3'h0, s != 2'h0, s != 2'h0, 1'b0, s[1], s[0]};
    endfunction
    function automatic logic [7:0] exp_jam(input logic [2:0] j);
        return {1'b0, j == pcp_pkg::JAM_ALARM, 3'h0, j == pcp_pkg::JAM_ALARM,
                j == pcp_pkg::JAM_AUX || j == pcp_pkg::JAM_BOTH,
                j == pcp_pkg::JAM_TRIP || j == pcp_pkg::JAM_BOTH};
    endfunction
    function automatic logic [7:0] exp_uc(input logic [1:0] u);
        return {u == pcp_pkg::UC_ALARM, 4'h0, u == pcp_pkg::UC_ALARM,
                u == pcp_pkg::UC_AUX, u == pcp_pkg::UC_TRIP};
    endfunction

    initial begin
        cyc(8);
        nrst <= 1'b1;
        cyc(1);
        // reset values, unmapped and read-only places
        rd(pcp_pkg::OFF_CTRL, 32'h0, pcp_pkg::RESP_OKAY);
        rd(pcp_pkg::OFF_SC, 32'h0000000b, pcp_pkg::RESP_OKAY);
        rd(pcp_pkg::OFF_IOL, 32'hffff006e, pcp_pkg::RESP_OKAY);
        rd(8'h20, 32'h0, pcp_pkg::RESP_SLVERR);
        wr(pcp_pkg::OFF_STATUS, 32'hffffffff, pcp_pkg::RESP_SLVERR);
        wr(pcp_pkg::OFF_RATING, 32'h006403e8, pcp_pkg::RESP_OKAY); // 1000 A ct, 100 A load
        wr(pcp_pkg::OFF_SC, 32'h00000002, pcp_pkg::RESP_OKAY);
        // short circuit at the exact pickup, every selection, during a start
        motorStarting <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(pcp_pkg::OFF_CTRL, 32'(i), pcp_pkg::RESP_OKAY);
            amps($random(seed) & 32'h3ff, 1999, 0);
            cyc(4);
            chk(outs, 8'h0);
            amps($random(seed) & 32'h3ff, 2000, 0);
            cyc(4);
            chk(outs, exp_sc(2'(i)));
            if (i == 1) rd(pcp_pkg::OFF_STATUS, 32'h919, pcp_pkg::RESP_OKAY);
            amps(0, 0, 0);
        end
        // 3 ms delay, broken once by a one-cycle dropout
        wr(pcp_pkg::OFF_CTRL, 32'(pcp_pkg::SC_TRIP), pcp_pkg::RESP_OKAY);
        wr(pcp_pkg::OFF_SC, 32'h00030002, pcp_pkg::RESP_OKAY);
        amps(0, 0, 2100);
        cyc(40);
        amps(0, 0, 0);
        cyc(1);
        amps(0, 0, 2100);
        cyc(2 * MS);
        chk(tripRelay, 1'b0);
        cyc(MS + 8);
        chk(tripRelay, 1'b1);
        // immediate overload at 1.5 x full load, strictly above
        motorStarting <= 1'b0;
        motorRunning <= 1'b1;
        wr(pcp_pkg::OFF_IOL, 32'hffff000f, pcp_pkg::RESP_OKAY);
        wr(pcp_pkg::OFF_CTRL, 32'h4, pcp_pkg::RESP_OKAY);
        amps(150, 150, 150);
        cyc(4);
        chk(outs, 8'h0);
        i = 151 + ($random(seed) & 32'h3f);
        amps(i, i, i);
        cyc(4);
        chk(outs, 8'h24);
        wr(pcp_pkg::OFF_CTRL, 32'h0, pcp_pkg::RESP_OKAY);
        cyc(3);
        chk(outs, 8'h0);
        motorRunning <= 1'b0;
        motorStarting <= 1'b1;
        wr(pcp_pkg::OFF_CTRL, 32'h4, pcp_pkg::RESP_OKAY);
        cyc(3 * MS);
        chk(outs, 8'h0);
        wr(pcp_pkg::OFF_IOL, 32'h0002000f, pcp_pkg::RESP_OKAY);
        cyc(3 * MS + 4);
        chk(outs, 8'h24);
        // jam at 2.0 x load, 1 ms, unlimited inhibit during start
        wr(pcp_pkg::OFF_JAM, 32'h00010014, pcp_pkg::RESP_OKAY);
        wr(pcp_pkg::OFF_CTRL, 32'(pcp_pkg::JAM_TRIP) << 3, pcp_pkg::RESP_OKAY);
        amps(250, 250, 250);
        cyc(3 * MS);
        chk(outs & 8'he7, 8'h0);
        motorStarting <= 1'b0;
        motorRunning <= 1'b1;
        for (i = 1; i < 5; i++) begin
            amps(200, 200, 200);
            wr(pcp_pkg::OFF_CTRL, 32'(i) << 3, pcp_pkg::RESP_OKAY);
            cyc(3 * MS);
            chk(outs & 8'he7, 8'h0);
            amps(201, 201, 201);
            cyc(2 * MS + 4);
            chk(outs & 8'he7, exp_jam(3'(i)));
            if (i == 1) chk(lastTripCause, pcp_pkg::CAUSE_JAM);
        end
        // undercurrent at 60 % of load, 1 ms, floor at 5 %
        wr(pcp_pkg::OFF_UC, 32'h0001003c, pcp_pkg::RESP_OKAY);
        for (i = 1; i < 4; i++) begin
            amps(60, 60, 60);
            wr(pcp_pkg::OFF_CTRL, 32'(i) << 6, pcp_pkg::RESP_OKAY);
            cyc(2 * MS + 4);
            chk(outs & 8'he7, 8'h0);
            amps(4, 4, 4);
            cyc(2 * MS + 4);
            chk(outs & 8'he7, 8'h0);
            amps(59, 59, 59);
            cyc(2 * MS + 4);
            chk(outs & 8'he7, exp_uc(2'(i)));
            if (i == 2) chk(lastTripCause, pcp_pkg::CAUSE_UC);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
